// [core/tx_interpolator_gain_control.sv]
// Transmit interpolator, gain control and delayed power-down behind an AXI4-Lite slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tx_interp_params.svh"


module tx_interpolator_gain_control #(
	parameter int DATA_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [DATA_W-1:0] tx_word,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic              tx_enable,
	input  wire logic              half_duplex,
	input  wire logic              receive_buffer_control,
	input  wire logic [5:0]        gain_setting_port,
	output logic [DATA_W-1:0]      dac_data,
	output logic                   tx_powerdown,
	output logic [3:0]             dac_atten,
	output logic [4:0]             amp_atten,
	output logic [3:0]             amp_standing_bias,
	output logic [3:0]             amp_signal_bias,
	output logic [5:0]             rx_gain
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [8:0] pin_meta_r;
	logic [8:0] pin_sync_r;
	logic       burst_s;
	logic       hdx_s;
	logic       rxsel_s;
	logic [5:0] port_s;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta_r <= 9'h000;
			pin_sync_r <= 9'h000;
		end
		else
		begin
			pin_meta_r <= {tx_enable, half_duplex, receive_buffer_control, gain_setting_port};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign burst_s = pin_sync_r[8];
	assign hdx_s   = pin_sync_r[7];
	assign rxsel_s = pin_sync_r[6];
	assign port_s  = pin_sync_r[5:0];

	// ****************************************************************
	// Register file over AXI4-Lite
	// ****************************************************************
	logic [5:0]  ctrl_r;
	logic [5:0]  tx_gain_r;
	logic [5:0]  rx_gain_r;
	logic [3:0]  stand_r;
	logic [3:0]  sig_r;
	logic        aw_held_r;
	logic        w_held_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_go;
	logic        pd_r;
	logic [1:0]  mode;
	logic        mode_wr;
	tx_interp_pkg::bus_state_type rd_state_r;

	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
	assign mode          = ctrl_r[`CTRL_MODE_LSB +: 2];
	assign mode_wr       = wr_go && awaddr_r == `CTRL_OFFSET && wstrb_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r    <= 1'b0;
			w_held_r     <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_r)
					`CTRL_OFFSET, `GAIN_OFFSET, `BIAS_OFFSET, `STATUS_OFFSET:
						s_axi_bresp <= 2'h0;
					default:
						s_axi_bresp <= 2'h2;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Control and bias fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r  <= `CTRL_RESET;
			stand_r <= `BIAS_RESET;
			sig_r   <= `BIAS_RESET;
		end
		else if (wr_go)
		begin
			if (mode_wr)
				ctrl_r <= wdata_r[5:0];
			if (awaddr_r == `BIAS_OFFSET && wstrb_r[0])
				stand_r <= wdata_r[`BIAS_STAND_LSB +: 4];
			if (awaddr_r == `BIAS_OFFSET && wstrb_r[1])
				sig_r <= wdata_r[`BIAS_SIG_LSB +: 4];
		end
	end

	// Transmit and receive gain; a register write wins over a port update in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_gain_r <= `GAIN_RESET;
			rx_gain_r <= `GAIN_RESET;
		end
		else
		begin
			if (wr_go && awaddr_r == `GAIN_OFFSET && wstrb_r[0])
				tx_gain_r <= wdata_r[5:0];
			else if (ctrl_r[`CTRL_PORT_EN] && hdx_s && !rxsel_s && burst_s)
				tx_gain_r <= port_s;
			if (!hdx_s || rxsel_s)
				rx_gain_r <= port_s;
		end
	end

	// Read channel answers one cycle after the address is taken
	assign s_axi_arready = rd_state_r == tx_interp_pkg::BUS_IDLE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_r   <= tx_interp_pkg::BUS_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else
		begin
			case (rd_state_r)
				tx_interp_pkg::BUS_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						rd_state_r   <= tx_interp_pkg::BUS_RESP;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp  <= 2'h0;
						s_axi_rdata  <= 32'h0000_0000;
						case (s_axi_araddr)
							`CTRL_OFFSET:
								s_axi_rdata[5:0] <= ctrl_r;
							`GAIN_OFFSET:
								s_axi_rdata[5:0] <= tx_gain_r;
							`BIAS_OFFSET:
							begin
								s_axi_rdata[`BIAS_STAND_LSB +: 4] <= stand_r;
								s_axi_rdata[`BIAS_SIG_LSB +: 4]   <= sig_r;
							end
							`STATUS_OFFSET:
							begin
								s_axi_rdata[5:0]                  <= tx_gain_r;
								s_axi_rdata[`STAT_PD_BIT]         <= pd_r;
								s_axi_rdata[`STAT_BURST_BIT]      <= burst_s;
								s_axi_rdata[`STAT_RXG_LSB +: 6]   <= rx_gain_r;
							end
							default:
								s_axi_rresp <= 2'h2;
						endcase
					end
				end
				tx_interp_pkg::BUS_RESP:
				begin
					if (s_axi_rready)
					begin
						rd_state_r   <= tx_interp_pkg::BUS_IDLE;
						s_axi_rvalid <= 1'b0;
					end
				end
				default:
					rd_state_r <= tx_interp_pkg::BUS_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Interpolation phase and word intake
	// ****************************************************************
	logic [1:0] ph_r;
	logic [1:0] ph_last;
	logic       take;
	logic       bypass;
	logic [DATA_W-1:0] word_in;

	// Mode code 3 is unused, so it falls back to bypass rather than a stray chain
	assign bypass = mode != `MODE_X2 && mode != `MODE_X4;

	always_comb
	begin
		case (mode)
			`MODE_X2: ph_last = 2'h1;
			`MODE_X4: ph_last = 2'h3;
			default:  ph_last = 2'h0;
		endcase
	end

	// Fixed slot per word keeps the output rate an exact multiple of the word rate
	assign tx_ready = ph_r == ph_last;
	assign take     = ph_r == ph_last;
	assign word_in  = tx_valid ? tx_word : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode_wr)
			ph_r <= 2'h0;
		else if (take)
			ph_r <= 2'h0;
		else
			ph_r <= ph_r + 2'h1;
	end

	// ****************************************************************
	// Half-band stages
	// ****************************************************************
	logic signed [DATA_W-1:0] h_r [0:21];
	logic signed [DATA_W-1:0] g_r [0:21];
	logic signed [DATA_W-1:0] s1_val;
	logic signed [DATA_W-1:0] s2_val;
	logic signed [DATA_W-1:0] stage_out;
	logic signed [35:0]       acc1;
	logic signed [35:0]       acc_lp;
	logic signed [35:0]       acc_bp;
	logic                     bp_sel;

	function automatic logic signed [DATA_W-1:0] scale_sat(input logic signed [35:0] acc);
		logic signed [35:0] s;
		s = acc >>> `COEF_FRAC;
		if (s > 36'sd0 + 2 ** (DATA_W - 1) - 1)
			return {1'b0, {(DATA_W - 1){1'b1}}};
		else if (s < -(36'sd0 + 2 ** (DATA_W - 1)))
			return {1'b1, {(DATA_W - 1){1'b0}}};
		else
			return s[DATA_W-1:0];
	endfunction

	// Stage one history shifts once per word, stage two once per stage one sample
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 22; i++)
			begin
				h_r[i] <= '0;
				g_r[i] <= '0;
			end
		end
		else
		begin
			if (take && !bypass)
			begin
				h_r[0] <= word_in;
				for (int i = 1; i < 22; i++)
					h_r[i] <= h_r[i-1];
			end
			if (mode == `MODE_X4 && !ph_r[0])
			begin
				g_r[0] <= s1_val;
				for (int i = 1; i < 22; i++)
					g_r[i] <= g_r[i-1];
			end
		end
	end

	// Odd phases: symmetric pair sums; 43 taps as 11 pairs plus centre, 11 taps as 3 pairs
	always_comb
	begin
		acc1   = '0;
		acc_lp = '0;
		acc_bp = '0;
		for (int k = 0; k < 11; k++)
		begin
			acc1   = acc1 + tx_interp_pkg::LONG_COEF[k] * (36'(h_r[10-k]) + 36'(h_r[11+k]));
			acc_bp = acc_bp - tx_interp_pkg::LONG_COEF[k] * (36'(g_r[10-k]) + 36'(g_r[11+k]));
		end
		for (int k = 0; k < 3; k++)
			acc_lp = acc_lp + tx_interp_pkg::SHORT_COEF[k] * (36'(g_r[2-k]) + 36'(g_r[3+k]));
	end

	assign bp_sel = ctrl_r[`CTRL_BANDPASS];
	// Stage one: even phase during the first half of the word slot
	assign s1_val = ((mode == `MODE_X4) ? ph_r[1] : ph_r[0]) ? scale_sat(acc1) : h_r[11];
	// Stage two: even phase right after each capture
	assign s2_val = ph_r[0] ? (bp_sel ? g_r[11] : g_r[3])
		: (bp_sel ? scale_sat(acc_bp) : scale_sat(acc_lp));
	assign stage_out = (mode == `MODE_X4) ? s2_val : s1_val;

	// ****************************************************************
	// Latency alignment
	// ****************************************************************
	logic signed [DATA_W-1:0] dly_r [0:`PAD_DEPTH-1];
	logic [6:0]               pad_sel;
	logic [6:0]               lat_now;

	always_comb
	begin
		case (mode)
			`MODE_X2:
			begin
				pad_sel = `LAT_X2 - `NAT_X2;
				lat_now = `LAT_X2;
			end
			`MODE_X4:
			begin
				pad_sel = bp_sel ? `LAT_X4 - `NAT_BP : `LAT_X4 - `NAT_X4;
				lat_now = `LAT_X4;
			end
			default:
			begin
				pad_sel = 7'd0;
				lat_now = `LAT_BYPASS;
			end
		endcase
	end

	// Shift register trades area for a latency that is exact in every mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < `PAD_DEPTH; i++)
				dly_r[i] <= '0;
			dac_data <= '0;
		end
		else
		begin
			dly_r[0] <= stage_out;
			for (int i = 1; i < `PAD_DEPTH; i++)
				dly_r[i] <= dly_r[i-1];
			if (bypass)
				dac_data <= word_in;
			else
				dac_data <= dly_r[pad_sel[5:0]];
		end
	end

	// ****************************************************************
	// Delayed power-down
	// ****************************************************************
	logic [6:0] pd_cnt_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pd_cnt_r <= 7'd0;
			pd_r     <= 1'b1;
		end
		else if (burst_s)
		begin
			pd_cnt_r <= lat_now;
			pd_r     <= 1'b0;
		end
		else if (pd_cnt_r != 7'd0)
			pd_cnt_r <= pd_cnt_r - 7'd1;
		else
			pd_r <= 1'b1;
	end

	assign tx_powerdown = pd_r;

	// ****************************************************************
	// Gain decode and bias outputs
	// ****************************************************************
	logic [5:0] code;
	logic [5:0] amp_part;
	logic [5:0] dac_part;

	always_comb
	begin
		code = (tx_gain_r > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : tx_gain_r;
		if (ctrl_r[`CTRL_AMP_EN])
			amp_part = (code > `AMP_ATT_MAX) ? `AMP_ATT_MAX : code;
		else
			amp_part = 6'h00;
		dac_part = code - amp_part;
		if (dac_part > `DAC_ATT_MAX)
			dac_part = `DAC_ATT_MAX;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dac_atten         <= 4'h0;
			amp_atten         <= 5'h00;
			amp_standing_bias <= `BIAS_RESET;
			amp_signal_bias   <= 4'h0;
		end
		else
		begin
			dac_atten         <= dac_part[3:0];
			amp_atten         <= amp_part[4:0];
			amp_standing_bias <= stand_r;
			amp_signal_bias   <= ctrl_r[`CTRL_VMODE] ? sig_r : 4'h0;
		end
	end

	assign rx_gain = rx_gain_r;

endmodule // tx_interpolator_gain_control

// [shared/tx_interp_params.svh]
// Offsets, field positions, reset values and latency counts of the transmit front end
`ifndef TX_INTERP_PARAMS_SVH
`define TX_INTERP_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTRL_OFFSET      8'h00
`define GAIN_OFFSET      8'h04
`define BIAS_OFFSET      8'h08
`define STATUS_OFFSET    8'h0c

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_MODE_LSB    0
`define CTRL_BANDPASS    2
`define CTRL_PORT_EN     3
`define CTRL_AMP_EN      4
`define CTRL_VMODE       5
`define MODE_BYPASS      2'h0
`define MODE_X2          2'h1
`define MODE_X4          2'h2
`define CTRL_RESET       6'h02

// ****************************************************************
// Gain and bias fields
// ****************************************************************
`define GAIN_RESET       6'h00
`define GAIN_MAX_CODE    6'h27
`define DAC_ATT_MAX      6'h0f
`define AMP_ATT_MAX      6'h18
`define BIAS_STAND_LSB   0
`define BIAS_SIG_LSB     8
`define BIAS_RESET       4'h8

// ****************************************************************
// Status fields
// ****************************************************************
`define STAT_PD_BIT      8
`define STAT_BURST_BIT   9
`define STAT_RXG_LSB     16

// ****************************************************************
// Latency in DAC update cycles, word taken to matching centre sample out
// ****************************************************************
`define LAT_X2           7'd43
`define LAT_X4           7'd96
`define LAT_BYPASS       7'd1
`define NAT_X2           7'd24
`define NAT_X4           7'd53
`define NAT_BP           7'd69
`define PAD_DEPTH        44
`define COEF_FRAC        15

`endif

// [shared/tx_interp_pkg.sv]
// Types and filter coefficient tables of the transmit front end
package tx_interp_pkg;

	typedef logic signed [15:0] coef_type;
	typedef coef_type           long_coef_type [0:10];
	typedef coef_type           short_coef_type [0:2];

	// Odd-phase half-band taps, one per symmetric pair, each set sums to one half
	localparam long_coef_type  LONG_COEF  = '{16'sh4f28, -16'sh16a8, 16'sh0bb8, -16'sh06d6,
		16'sh0438, -16'sh02a8, 16'sh01a4, -16'sh00fa, 16'sh008c, -16'sh0046, 16'sh001e};
	localparam short_coef_type SHORT_COEF = '{16'sh4ccc, -16'sh1333, 16'sh0667};

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_RESP
	} bus_state_type;

endpackage

// [dv/tx_interp_assertions.sv]
// Port checker of the transmit front end, bound to the design top
`timescale 1ns/100ps

// ****************************************
// Checker
// ****************************************
module tx_interp_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       tx_ready,
	input wire logic       tx_enable,
	input wire logic       tx_powerdown,
	input wire logic [3:0] dac_atten,
	input wire logic [4:0] amp_atten,
	input wire logic       receive_buffer_control,
	input wire logic [5:0] gain_setting_port,
	input wire logic [5:0] rx_gain
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_reset_vals;
		$rose(aresetn) |-> tx_powerdown && dac_atten == 4'h0 && amp_atten == 5'h0 && rx_gain == 6'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset outputs wrong");

	// First slot lands on the fourth cycle only if the chain wakes in 4x
	property p_reset_mode;
		$rose(aresetn) |-> (!tx_ready) [*3] ##1 tx_ready;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("slot spacing after reset");

	property p_pd_wake;
		$rose(tx_enable) |-> ##[1:4] !tx_powerdown;
	endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("power-up late");

	// Delay within five cycles above the mode latency is judged by the bench; here only a bound on the wait
	property p_pd_sleep;
		$fell(tx_enable) |-> ##[2:110] tx_powerdown;
	endproperty
	a_pd_sleep: assert property (p_pd_sleep) else $error("power-down missing");

	property p_rx_steer;
		(receive_buffer_control && $stable(gain_setting_port)) [*4] |-> rx_gain == gain_setting_port;
	endproperty
	a_rx_steer: assert property (p_rx_steer) else $error("rx gain not loaded");

	property p_gain_split;
		dac_atten != 4'h0 |-> amp_atten == 5'h0 || amp_atten == 5'h18;
	endproperty
	a_gain_split: assert property (p_gain_split) else $error("gain split wrong");

	property p_amp_range;
		amp_atten <= 5'h18;
	endproperty
	a_amp_range: assert property (p_amp_range) else $error("amp range exceeded");

	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

	property p_wr_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write response stuck");

	c_burst_end: cover property ($fell(tx_enable));
	c_rx_load: cover property ($changed(rx_gain));
	c_split: cover property (dac_atten != 4'h0 && amp_atten == 5'h18);
endmodule // tx_interp_checker

bind tx_interpolator_gain_control tx_interp_checker u_tx_interp_checker (.*);

// [dv/baseband_source.sv]
// Behavioural baseband controller feeding transmit words
`timescale 1ns/100ps

// ****************************************
// Word source
// ****************************************
module baseband_source #(
	parameter int DATA_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              tx_ready,
	input  wire logic              send_req,
	input  wire logic [DATA_W-1:0] send_word,
	output logic [DATA_W-1:0]      tx_word = '0,
	output logic                   tx_valid = 1'h0,
	output logic                   sent = 1'h0
);
	logic pend_r = 1'h0;

	always @(posedge aclk)
	begin
		sent <= 1'h0;
		if (!aresetn)
		begin
			tx_valid <= 1'h0;
			tx_word  <= ~tx_word;  // Not driving yet: keeps moving so no stale value reads
			pend_r   <= 1'h0;
		end
		else if (send_req)
		begin
			tx_word  <= send_word;
			tx_valid <= 1'h1;
			pend_r   <= 1'h1;
		end
		else if (tx_ready)  // One word per offered slot keeps the word rate legal
		begin
			tx_word  <= '0;
			tx_valid <= 1'h1;
			sent     <= pend_r;
			pend_r   <= 1'h0;
		end
	end
endmodule // baseband_source

// [dv/tx_interpolator_gain_control_tb.sv]
// Self-checking testbench of the transmit front end
`timescale 1ns/100ps
`include "tx_interp_params.svh"

// ****************************************
// Testbench top
// ****************************************
module tx_interpolator_gain_control_tb;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        tx_enable = 1'h0, half_duplex = 1'h0, receive_buffer_control = 1'h0;
	logic [5:0]  gain_setting_port = 6'h0, rx_gain;
	logic [11:0] tx_word, dac_data, send_word = 12'h0;
	logic        tx_valid, tx_ready, tx_powerdown, send_req = 1'h0, sent;
	logic [3:0]  dac_atten, amp_standing_bias, amp_signal_bias;
	logic [4:0]  amp_atten;
	int          error_cnt = 0;
	int          tests_run = 0;

	tx_interpolator_gain_control u_tx_interpolator_gain_control (.*);
	baseband_source u_baseband_source (.*);

	always #25 aclk = ~aclk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic fail_wait();
		chk("wait_bound", 1'h0, 1'h1);
		tally_and_finish();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int n = 0; n < 40 && !done; n++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
			begin
				chk("bresp", s_axi_bresp, er);
				s_axi_bready <= 1'h0;
				done = 1;
			end
		end
		if (!done)
			fail_wait();
		// Let the released bready settle before a following call raises it again
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
		input string nm);
		bit done;
		done = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int n = 0; n < 40 && !done; n++)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
			begin
				chk("rresp", s_axi_rresp, er);
				chk(nm, s_axi_rdata, ed);
				s_axi_rready <= 1'h0;
				done = 1;
			end
		end
		if (!done)
			fail_wait();
		@(posedge aclk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("rst_out", {tx_powerdown, amp_signal_bias, amp_standing_bias, dac_atten, amp_atten},
			18'h21000);
		axi_rd(`CTRL_OFFSET, 32'h2, 2'h0, "ctrl_rst");
		axi_rd(`GAIN_OFFSET, 32'h0, 2'h0, "gain_rst");
		axi_rd(`BIAS_OFFSET, 32'h808, 2'h0, "bias_rst");
		axi_rd(`STATUS_OFFSET, 32'h100, 2'h0, "stat_rst");
		axi_rd(8'h10, 32'h0, 2'h2, "unmapped");
		axi_wr(8'h10, 32'hffffffff, 2'h2);
		axi_wr(`STATUS_OFFSET, 32'h0, 2'h0);
	endtask

	// Every mode: slot rate per 16 cycles, then one lone word timed to its centre sample
	task automatic t_modes();
		logic [5:0] ctl [5] = '{6'h00, 6'h03, 6'h01, 6'h02, 6'h06};
		int lat [5] = '{0, 0, 43, 96, 96};
		int slot [5] = '{16, 16, 8, 4, 4};
		int cnt;
		bit seen;
		for (int m = 0; m < 5; m++)
		begin
			axi_wr(`CTRL_OFFSET, {26'h0, ctl[m]}, 2'h0);
			cnt = 0;
			repeat (16)
			begin
				@(posedge aclk);
				cnt += tx_ready;
			end
			chk("slots", cnt, slot[m]);
			send_word <= 12'h400;
			send_req <= 1'h1;
			@(posedge aclk);
			send_req <= 1'h0;
			seen = 0;
			for (int n = 0; n < 20 && !seen; n++)
			begin
				@(posedge aclk);
				seen = sent;
			end
			if (!seen)
				fail_wait();
			repeat (lat[m]) @(posedge aclk);
			chk("centre", dac_data, 12'h400);
			repeat (120) @(posedge aclk);
		end
	endtask

	task automatic t_power();
		int lat [2] = '{43, 96};
		int n;
		for (int m = 0; m < 2; m++)
		begin
			axi_wr(`CTRL_OFFSET, 32'h1 << m, 2'h0);
			tx_enable <= 1'h1;
			repeat (6) @(posedge aclk);
			chk("pd_on", tx_powerdown, 1'h0);
			tx_enable <= 1'h0;
			n = 0;
			while (n < 200 && tx_powerdown !== 1'h1)
			begin
				@(posedge aclk);
				n++;
			end
			if (n == 200)
				fail_wait();
			chk("pd_delay", n >= lat[m] && n <= lat[m] + 5, 1'h1);
		end
	endtask

	task automatic t_gain();
		logic [5:0] ctl [4] = '{6'h12, 6'h12, 6'h12, 6'h02};
		logic [5:0] code [4] = '{6'h14, 6'h1e, 6'h3f, 6'h0a};
		logic [8:0] att [4] = '{9'h140, 9'h186, 9'h18f, 9'h00a};
		for (int i = 0; i < 4; i++)
		begin
			axi_wr(`CTRL_OFFSET, {26'h0, ctl[i]}, 2'h0);
			axi_wr(`GAIN_OFFSET, {26'h3ffffff, code[i]}, 2'h0);
			repeat (4) @(posedge aclk);
			chk("atten", {amp_atten, dac_atten}, att[i]);
		end
		axi_rd(`GAIN_OFFSET, 32'h0a, 2'h0, "gain_reg");
	endtask

	task automatic t_port();
		axi_wr(`GAIN_OFFSET, 32'h0, 2'h0);
		axi_wr(`CTRL_OFFSET, 32'h12, 2'h0);
		half_duplex <= 1'h1;
		tx_enable <= 1'h1;
		gain_setting_port <= 6'h05;
		repeat (8) @(posedge aclk);
		chk("port_off", amp_atten, 5'h0);
		axi_wr(`CTRL_OFFSET, 32'h1a, 2'h0);
		repeat (8) @(posedge aclk);
		chk("port_on", amp_atten, 5'h05);
		receive_buffer_control <= 1'h1;
		gain_setting_port <= 6'h09;
		repeat (8) @(posedge aclk);
		chk("rx_steer", rx_gain, 6'h09);
		chk("tx_kept", amp_atten, 5'h05);
		receive_buffer_control <= 1'h0;
		tx_enable <= 1'h0;
		gain_setting_port <= 6'h07;
		repeat (8) @(posedge aclk);
		chk("no_burst", amp_atten, 5'h05);
		half_duplex <= 1'h0;
		repeat (120) @(posedge aclk);
		axi_rd(`STATUS_OFFSET, 32'h00070105, 2'h0, "stat_port");
	endtask

	task automatic t_bias();
		axi_wr(`BIAS_OFFSET, 32'h305, 2'h0);
		axi_wr(`CTRL_OFFSET, 32'h02, 2'h0);
		repeat (4) @(posedge aclk);
		chk("bias_cur", {amp_signal_bias, amp_standing_bias}, 8'h05);
		axi_wr(`CTRL_OFFSET, 32'h22, 2'h0);
		repeat (4) @(posedge aclk);
		chk("bias_volt", {amp_signal_bias, amp_standing_bias}, 8'h35);
		axi_rd(`BIAS_OFFSET, 32'h305, 2'h0, "bias_reg");
	endtask

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (6) @(posedge aclk);
		t_reset();
		t_modes();
		t_power();
		t_gain();
		t_port();
		t_bias();
		tally_and_finish();
	end
endmodule // tx_interpolator_gain_control_tb
